// File: verilog/bji_core.v
// Control-flow and indexed-addressing execution unit with Avalon-MM registers
//
// Function
// - Relative subroutine call reaches -126..+129 from its first byte, relative only.
// - Absolute subroutine call accepts indexed, extended and direct modes.
// - No-operation only advances program counter by one.
// - Conditional branches form eight complementary pairs using offset byte.
// - Branch-never never transfers control, complements branch-always.
// - Signed branches include overflow flag in test.
// - Unsigned branches use carry and zero only.
// - Simple branches each test one flag.
// - Index compare sets N, Z, V and C like a 16-bit compare; H and I unchanged.
// - Indexed address is index plus unsigned offset byte.
// - Indexed address held in temp ea_ff, readable at the EA offset; index unchanged.
// - Indexed index load reads two bytes at the indexed address, replaces index.
// - Immediate index load places instruction constant in index.
// - Direct addressing reaches only page zero 0x00..0xFF.
// - One indexed instruction reaches 256 locations from index.
// - Interrupt sets mask; masked wait released only by non-maskable.
// - Return from interrupt restores every flag from stack.
// - Subroutine calls push return address then load target.
// - Subroutine return pulls two-byte address into program counter.
// - Stack grows down; pointer decrements per push, increments per pull.
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
module bji_core
(
  // Clock and reset
  input wire mclk_in,
  input wire rst_in,
  // Avalon-MM slave
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // Memory port
  output reg [15:0] mem_addr_out,
  output reg [7:0] mem_wdata_out,
  output reg mem_we_out,
  output reg mem_re_out,
  input wire [7:0] mem_rdata_in,
  // Interrupt pins
  input wire irq_in,
  input wire nmi_in,
  // State
  output wire waiting_out
);
`include "bji_defs.vh"
// ==========================================
// Execution states
localparam ST_IDLE = 6'b000001;
localparam ST_RD = 6'b000010;
localparam ST_WR = 6'b000100;
localparam ST_WAIT = 6'b001000;
localparam ST_DONE = 6'b010000;
localparam ST_EXEC = 6'b100000;
reg [5:0] state_ff, nxt_state;
reg [7:0] opcode_ff, ccr_ff, nxt_ccr, nxt_opcode, mwd;
reg [15:0] operand_ff, x_ff, nxt_x, sp_ff, nxt_sp, pc_ff, nxt_pc, ea_ff, nxt_ea;
reg [15:0] tmp_ff, nxt_tmp, mdata_ff;
reg [2:0] cnt_ff, nxt_cnt, nbytes_ff, nxt_nbytes;
reg busy_ff, nxt_busy, pend_rsp_ff, mwe, mre;
reg [15:0] nxt_operand, nxt_mdata, maddr;
reg [1:0] irq_sync_ff, nmi_sync_ff;
wire take;
wire irq_s = irq_sync_ff[1];
wire nmi_s = nmi_sync_ff[1];
wire wr_go = avs_write_in & ~busy_ff;
wire [16:0] cpx_diff = {1'b0, x_ff} - {1'b0, operand_ff};
// ==========================================
// Branch decision
bji_cond_eval u_cond
(
  .sel_in(opcode_ff[3:0]),
  .ccr_in(ccr_ff),
  .take_out(take)
);
assign waiting_out = state_ff[3];
// Reads answer one cycle after they are seen; writes stall while busy
assign avs_waitrequest_out = (avs_read_in & ~pend_rsp_ff) | (avs_write_in & busy_ff);
// ==========================================
// Pin synchronisers
always @(posedge mclk_in or posedge rst_in)
begin
  if (rst_in)
  begin
    irq_sync_ff <= 2'h0;
    nmi_sync_ff <= 2'h0;
  end
  else
  begin
    irq_sync_ff <= {irq_sync_ff[0], irq_in};
    nmi_sync_ff <= {nmi_sync_ff[0], nmi_in};
  end
end
// ==========================================
// Instruction sequencer
always @*
begin
  nxt_state = state_ff;
  nxt_ccr = ccr_ff;
  nxt_x = x_ff;
  nxt_sp = sp_ff;
  nxt_pc = pc_ff;
  nxt_ea = ea_ff;
  nxt_tmp = tmp_ff;
  nxt_cnt = cnt_ff;
  nxt_nbytes = nbytes_ff;
  nxt_busy = busy_ff;
  nxt_opcode = opcode_ff;
  nxt_operand = operand_ff;
  nxt_mdata = mdata_ff;
  maddr = 16'h0000;
  mwd = 8'h00;
  mwe = 1'b0;
  mre = 1'b0;
  case (state_ff)
    ST_IDLE:
    begin
      if (wr_go)
      begin
        case (avs_address_in)
          `BJI_OFF_CTRL: if (avs_writedata_in[0])
          begin
            nxt_busy = 1'b1;
            nxt_state = ST_EXEC;
          end
          `BJI_OFF_OPCODE: nxt_opcode = avs_writedata_in[7:0];
          `BJI_OFF_OPERAND: nxt_operand = avs_writedata_in[15:0];
          `BJI_OFF_CCR: nxt_ccr = avs_writedata_in[7:0];
          `BJI_OFF_INDEX: nxt_x = avs_writedata_in[15:0];
          `BJI_OFF_STACK: nxt_sp = avs_writedata_in[15:0];
          `BJI_OFF_PC: nxt_pc = avs_writedata_in[15:0];
          default: nxt_state = ST_IDLE;
        endcase
      end
    end
    ST_EXEC:
    begin
      nxt_cnt = 3'h0;
      nxt_state = ST_DONE;
      if (opcode_ff[7:4] == `BJI_BR_HI)
      begin
        nxt_pc = pc_ff + 16'h0002;
        if (take)
          nxt_pc = pc_ff + 16'h0002 + {{8{operand_ff[7]}}, operand_ff[7:0]};
      end
      else
      begin
        case (opcode_ff)
          `BJI_OP_NOP: nxt_pc = pc_ff + 16'h0001;
          `BJI_OP_CPX_IMM:
          begin
            nxt_pc = pc_ff + 16'h0003;
            nxt_ccr[`BJI_CC_Z] = (cpx_diff[15:0] == 16'h0000);
            nxt_ccr[`BJI_CC_N] = cpx_diff[15];
            nxt_ccr[`BJI_CC_C] = cpx_diff[16];
            nxt_ccr[`BJI_CC_V] = (x_ff[15] ^ operand_ff[15]) & (x_ff[15] ^ cpx_diff[15]);
          end
          `BJI_OP_LDX_IMM:
          begin
            nxt_pc = pc_ff + 16'h0003;
            nxt_x = operand_ff;
            nxt_ccr[`BJI_CC_N] = operand_ff[15];
            nxt_ccr[`BJI_CC_Z] = (operand_ff == 16'h0000);
            nxt_ccr[`BJI_CC_V] = 1'b0;
          end
          `BJI_OP_LDX_IDX:
          begin
            nxt_pc = pc_ff + 16'h0002;
            nxt_ea = x_ff + {8'h00, operand_ff[7:0]};
            nxt_nbytes = 3'h2;
            nxt_state = ST_RD;
          end
          `BJI_OP_BSR, `BJI_OP_JSR_DIR, `BJI_OP_JSR_IDX, `BJI_OP_JSR_EXT:
          begin
            nxt_tmp = pc_ff + ((opcode_ff == `BJI_OP_JSR_EXT) ? 16'h0003 : 16'h0002);
            case (opcode_ff)
              `BJI_OP_BSR: nxt_ea = pc_ff + 16'h0002 + {{8{operand_ff[7]}}, operand_ff[7:0]};
              `BJI_OP_JSR_DIR: nxt_ea = {8'h00, operand_ff[7:0]};
              `BJI_OP_JSR_IDX: nxt_ea = x_ff + {8'h00, operand_ff[7:0]};
              default: nxt_ea = operand_ff;
            endcase
            nxt_nbytes = 3'h2;
            nxt_state = ST_WR;
          end
          `BJI_OP_RTS:
          begin
            nxt_nbytes = 3'h2;
            nxt_state = ST_RD;
          end
          `BJI_OP_RTI:
          begin
            nxt_nbytes = 3'h7;
            nxt_state = ST_RD;
          end
          `BJI_OP_WAI:
          begin
            nxt_pc = pc_ff + 16'h0001;
            nxt_state = ST_WAIT;
          end
          default: nxt_pc = pc_ff + 16'h0001;
        endcase
      end
    end
    ST_WR:
    begin
      // Push return address low byte first, stack grows down
      mwe = 1'b1;
      maddr = sp_ff;
      mwd = (cnt_ff == 3'h0) ? tmp_ff[7:0] : tmp_ff[15:8];
      nxt_sp = sp_ff - 16'h0001;
      nxt_cnt = cnt_ff + 3'h1;
      if (cnt_ff == nbytes_ff - 3'h1)
      begin
        nxt_pc = ea_ff;
        nxt_state = ST_DONE;
      end
    end
    ST_RD:
    begin
      // Address goes out one cycle; its byte is taken while the strobe stands
      mre = (cnt_ff != nbytes_ff);
      nxt_cnt = cnt_ff + 3'h1;
      if (!mre)
        nxt_state = ST_DONE;
      if (opcode_ff == `BJI_OP_LDX_IDX)
        maddr = ea_ff + {13'h0000, cnt_ff};
      else
      begin
        maddr = sp_ff + 16'h0001;
        if (mre)
          nxt_sp = sp_ff + 16'h0001;
      end
      if (mem_re_out)
      begin
        if (opcode_ff == `BJI_OP_LDX_IDX)
        begin
          if (cnt_ff == 3'h1)
            nxt_tmp = {mem_rdata_in, tmp_ff[7:0]};
          else
          begin
            nxt_x = {tmp_ff[15:8], mem_rdata_in};
            nxt_mdata = {tmp_ff[15:8], mem_rdata_in};
            nxt_ccr[`BJI_CC_N] = tmp_ff[15];
            nxt_ccr[`BJI_CC_Z] = ({tmp_ff[15:8], mem_rdata_in} == 16'h0000);
            nxt_ccr[`BJI_CC_V] = 1'b0;
          end
        end
        else if (opcode_ff == `BJI_OP_RTS)
        begin
          if (cnt_ff == 3'h1)
            nxt_pc = {mem_rdata_in, pc_ff[7:0]};
          else
            nxt_pc = {pc_ff[15:8], mem_rdata_in};
        end
        else
        begin
          case (cnt_ff)
            3'h1: nxt_ccr = {2'b11, mem_rdata_in[5:0]};
            3'h4: nxt_x = {mem_rdata_in, x_ff[7:0]};
            3'h5: nxt_x = {x_ff[15:8], mem_rdata_in};
            3'h6: nxt_pc = {mem_rdata_in, pc_ff[7:0]};
            3'h7: nxt_pc = {pc_ff[15:8], mem_rdata_in};
            default: nxt_mdata = {mdata_ff[7:0], mem_rdata_in};
          endcase
        end
      end
    end
    ST_WAIT:
    begin
      // Masked wait leaves only on the non-maskable line
      if (nmi_s | (irq_s & ~ccr_ff[`BJI_CC_I]))
      begin
        nxt_ccr[`BJI_CC_I] = 1'b1;
        nxt_state = ST_DONE;
      end
    end
    ST_DONE:
    begin
      nxt_busy = 1'b0;
      nxt_state = ST_IDLE;
    end
    default: nxt_state = ST_IDLE;
  endcase
end
// ==========================================
// State registers
always @(posedge mclk_in or posedge rst_in)
begin
  if (rst_in)
  begin
    state_ff <= ST_IDLE;
    ccr_ff <= `BJI_RST_CCR;
    x_ff <= 16'h0000;
    sp_ff <= `BJI_RST_SP;
    pc_ff <= 16'h0000;
    ea_ff <= 16'h0000;
    tmp_ff <= 16'h0000;
    cnt_ff <= 3'h0;
    nbytes_ff <= 3'h0;
    busy_ff <= 1'b0;
    opcode_ff <= `BJI_OP_NOP;
    operand_ff <= 16'h0000;
    mdata_ff <= 16'h0000;
    mem_addr_out <= 16'h0000;
    mem_wdata_out <= 8'h00;
    mem_we_out <= 1'b0;
    mem_re_out <= 1'b0;
  end
  else
  begin
    state_ff <= nxt_state;
    ccr_ff <= nxt_ccr;
    x_ff <= nxt_x;
    sp_ff <= nxt_sp;
    pc_ff <= nxt_pc;
    ea_ff <= nxt_ea;
    tmp_ff <= nxt_tmp;
    cnt_ff <= nxt_cnt;
    nbytes_ff <= nxt_nbytes;
    busy_ff <= nxt_busy;
    opcode_ff <= nxt_opcode;
    operand_ff <= nxt_operand;
    mdata_ff <= nxt_mdata;
    mem_addr_out <= maddr;
    mem_wdata_out <= mwd;
    mem_we_out <= mwe;
    mem_re_out <= mre;
  end
end
// ==========================================
// Register read path
always @(posedge mclk_in or posedge rst_in)
begin
  if (rst_in)
  begin
    pend_rsp_ff <= 1'b0;
    avs_readdata_out <= 32'h00000000;
  end
  else
  begin
    pend_rsp_ff <= avs_read_in & ~pend_rsp_ff;
    case (avs_address_in)
      `BJI_OFF_CTRL: avs_readdata_out <= {31'h00000000, busy_ff};
      `BJI_OFF_OPCODE: avs_readdata_out <= {24'h000000, opcode_ff};
      `BJI_OFF_OPERAND: avs_readdata_out <= {16'h0000, operand_ff};
      `BJI_OFF_CCR: avs_readdata_out <= {24'h000000, ccr_ff};
      `BJI_OFF_INDEX: avs_readdata_out <= {16'h0000, x_ff};
      `BJI_OFF_STACK: avs_readdata_out <= {16'h0000, sp_ff};
      `BJI_OFF_PC: avs_readdata_out <= {16'h0000, pc_ff};
      `BJI_OFF_EA: avs_readdata_out <= {16'h0000, ea_ff};
      `BJI_OFF_MEMDATA: avs_readdata_out <= {16'h0000, mdata_ff};
      `BJI_OFF_STATUS: avs_readdata_out <= {26'h0000000, state_ff};
      `BJI_OFF_IRQ: avs_readdata_out <= {30'h00000000, nmi_s, irq_s};
      default: avs_readdata_out <= 32'h00000000;
    endcase
  end
end
endmodule // bji_core

// File: inc/bji_defs.vh
// Constants for the branch, jump and index unit
`ifndef BJI_DEFS_VH
`define BJI_DEFS_VH
// ==========================================
// Register offsets (word addresses, one per register)
`define BJI_OFF_CTRL 4'h0
`define BJI_OFF_OPCODE 4'h1
`define BJI_OFF_OPERAND 4'h2
`define BJI_OFF_CCR 4'h3
`define BJI_OFF_INDEX 4'h4
`define BJI_OFF_STACK 4'h5
`define BJI_OFF_PC 4'h6
`define BJI_OFF_EA 4'h7
`define BJI_OFF_MEMDATA 4'h8
`define BJI_OFF_STATUS 4'h9
`define BJI_OFF_IRQ 4'hA
// ==========================================
// Condition code bit positions
`define BJI_CC_C 0
`define BJI_CC_V 1
`define BJI_CC_Z 2
`define BJI_CC_N 3
`define BJI_CC_I 4
`define BJI_CC_H 5
// ==========================================
// Opcodes handled
`define BJI_OP_NOP 8'h01
`define BJI_OP_RTS 8'h39
`define BJI_OP_RTI 8'h3B
`define BJI_OP_WAI 8'h3E
`define BJI_OP_BSR 8'h8D
`define BJI_OP_CPX_IMM 8'h8C
`define BJI_OP_LDX_IMM 8'hCE
`define BJI_OP_LDX_IDX 8'hEE
`define BJI_OP_JSR_DIR 8'h9D
`define BJI_OP_JSR_IDX 8'hAD
`define BJI_OP_JSR_EXT 8'hBD
`define BJI_BR_HI 4'h2
// ==========================================
// Reset values
`define BJI_RST_CCR 8'hD0
`define BJI_RST_SP 16'h00FF
`endif

// File: verilog/bji_cond_eval.v
// Branch condition evaluator for the sixteen relative branches
`timescale 1ns/100ps
module bji_cond_eval
(
  // Branch selector and flags
  input wire [3:0] sel_in,
  input wire [7:0] ccr_in,
  // Decision
  output reg take_out
);
`include "bji_defs.vh"
wire c = ccr_in[`BJI_CC_C];
wire v = ccr_in[`BJI_CC_V];
wire z = ccr_in[`BJI_CC_Z];
wire n = ccr_in[`BJI_CC_N];
reg base;
always @*
begin
  // Even codes test a condition, odd codes the complement
  case (sel_in[3:1])
    3'h0: base = 1'b1;
    3'h1: base = ~(c | z);
    3'h2: base = ~c;
    3'h3: base = ~z;
    3'h4: base = ~v;
    3'h5: base = ~n;
    3'h6: base = ~(n ^ v);
    3'h7: base = ~(z | (n ^ v));
    default: base = 1'b0;
  endcase
  take_out = base ^ sel_in[0];
end
endmodule // bji_cond_eval

// File: dv/bji_core_asserts.sv
// Port checker for the branch, jump and index unit
`timescale 1ns/100ps
module bji_core_asserts
(
  // Clock and reset
  input wire mclk_in,
  input wire rst_in,
  // Register bus
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  // Memory and pins
  input wire [15:0] mem_addr_out,
  input wire mem_we_out,
  input wire mem_re_out,
  input wire irq_in,
  input wire nmi_in,
  input wire waiting_out
);
  // ====
  // Wake cause tracking
  reg seen_int_ff;
  always @(posedge mclk_in or posedge rst_in)
    if (rst_in)
      seen_int_ff <= 1'b0;
    else
      seen_int_ff <= waiting_out & (seen_int_ff | irq_in | nmi_in);
  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // ====
  // Properties
  a_read_answer: assert property (avs_read_in |-> ##[0:1] !avs_waitrequest_out)
    else $error("read not answered");
  a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out
    && avs_address_in > 4'hA |-> avs_readdata_out == 32'h0) else $error("unmapped read");
  a_strobe_excl: assert property (!(mem_we_out && mem_re_out))
    else $error("read and write strobes together");
  a_push_down: assert property (mem_we_out && $past(mem_we_out)
    |-> mem_addr_out == $past(mem_addr_out) - 16'h1) else $error("push not downward");
  a_pull_up: assert property (mem_re_out && $past(mem_re_out)
    |-> mem_addr_out == $past(mem_addr_out) + 16'h1) else $error("pull not upward");
  a_wake_cause: assert property ($fell(waiting_out) |-> seen_int_ff)
    else $error("wait left without interrupt");
  a_wait_quiet: assert property (waiting_out && $past(waiting_out)
    |-> !mem_we_out && !mem_re_out) else $error("memory busy while waiting");
  a_reset_quiet: assert property (@(posedge mclk_in) disable iff (1'b0)
    rst_in |-> !mem_we_out && !mem_re_out && !waiting_out) else $error("active in reset");
  cover property (mem_we_out ##1 mem_we_out);
  cover property (mem_re_out ##1 mem_re_out);
  cover property ($fell(waiting_out));
endmodule // bji_core_asserts

bind bji_core bji_core_asserts bji_core_asserts_inst (.mclk_in, .rst_in, .avs_address_in,
  .avs_read_in, .avs_readdata_out, .avs_waitrequest_out, .mem_addr_out, .mem_we_out,
  .mem_re_out, .irq_in, .nmi_in, .waiting_out);

// File: dv/bji_mem_model.sv
// Behavioural program and data memory
`timescale 1ns/100ps
module bji_mem_model
(
  // Clock
  input wire mclk_in,
  // Byte port
  input wire [15:0] addr_in,
  input wire [7:0] wdata_in,
  input wire we_in,
  input wire re_in,
  output wire [7:0] rdata_out
);
  reg [7:0] mem [0:65535];
  integer i;
  initial
    for (i = 0; i < 65536; i = i + 1)
      mem[i] = i[7:0] ^ 8'hA5;
  always @(posedge mclk_in)
    if (we_in)
      mem[addr_in] <= wdata_in;
  // Idle bus shows a changing pattern, not the last byte
  assign rdata_out = re_in ? mem[addr_in] : ~addr_in[7:0];
endmodule // bji_mem_model

// File: dv/testbench.sv
// Self-checking bench for the branch, jump and index unit
`timescale 1ns/100ps
module testbench;
  reg mclk_in = 1'b0;
  reg rst_in = 1'b0;
  reg [3:0] avs_address_in = 4'h0;
  reg avs_read_in = 1'b0;
  reg avs_write_in = 1'b0;
  reg [31:0] avs_writedata_in = 32'h0;
  reg irq_in = 1'b0;
  reg nmi_in = 1'b0;
  wire [31:0] avs_readdata_out;
  wire avs_waitrequest_out;
  wire [15:0] mem_addr_out;
  wire [7:0] mem_wdata_out;
  wire [7:0] mem_rdata_in;
  wire mem_we_out;
  wire mem_re_out;
  wire waiting_out;
  integer miscompares = 0;
  integer n_checks = 0;
  integer s;
  integer k;
  reg [31:0] rd;
  reg [39:0] rows [0:255];
  always #2 mclk_in = ~mclk_in;
  bji_core bji_core_inst (.mclk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .mem_addr_out,
    .mem_wdata_out, .mem_we_out, .mem_re_out, .mem_rdata_in, .irq_in, .nmi_in, .waiting_out);
  bji_mem_model bji_mem_model_inst (.mclk_in, .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .we_in(mem_we_out), .re_in(mem_re_out),
    .rdata_out(mem_rdata_in));
  // ====
  // Tasks
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        miscompares = miscompares + 1;
        $display("BAD %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      avs_write_in <= w;
      avs_read_in <= ~w;
      avs_address_in <= a;
      avs_writedata_in <= d;
      @(posedge mclk_in);
      while (avs_waitrequest_out !== 1'b0)
        @(posedge mclk_in);
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge mclk_in);
    end
  endtask
  task rdc(input [3:0] a, input [63:0] nm, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd);
    end
  endtask
  task poll;
    begin
      s = 0;
      rd = 32'h1;
      while (rd[0] !== 1'b0 && s < 40)
      begin
        bus(1'b0, 4'h0, 32'h0);
        s = s + 1;
      end
      if (rd[0] !== 1'b0)
        miscompares = miscompares + 1;
    end
  endtask
  task exec(input [7:0] op, input [15:0] opd);
    begin
      bus(1'b1, 4'h1, {24'h0, op});
      bus(1'b1, 4'h2, {16'h0, opd});
      bus(1'b1, 4'h0, 32'h1);
      poll;
    end
  endtask
  function taken(input [3:0] c, input [3:0] f);
    reg r;
    begin
      case (c[3:1])
        3'h0: r = 1'b1;
        3'h1: r = ~(f[0] | f[2]);
        3'h2: r = ~f[0];
        3'h3: r = ~f[2];
        3'h4: r = ~f[1];
        3'h5: r = ~f[3];
        3'h6: r = ~(f[3] ^ f[1]);
        default: r = ~(f[2] | (f[3] ^ f[1]));
      endcase
      taken = r ^ c[0];
    end
  endfunction
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // ====
  // Watchdog
  initial
  begin
    #(4 * 40000);
    miscompares = miscompares + 1;
    tally_and_finish;
  end
  // ====
  // Main sequence
  initial
  begin
    rst_in <= 1'b1;
    for (k = 0; k < 256; k = k + 1)
      rows[k] = {4'h2, k[3:0], 4'hC, k[7:4], k[4] ? 8'h7F : 8'h80,
        taken(k[3:0], k[7:4]) ? (k[4] ? 16'h1081 : 16'h0F82) : 16'h1002};
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    rdc(4'h3, "ccr", 32'hD0);
    rdc(4'h5, "sp", 32'hFF);
    rdc(4'hF, "unmapped", 32'h0);
    $display("reset test done");
    for (k = 0; k < 256; k = k + 1)
    begin
      bus(1'b1, 4'h3, {24'h0, rows[k][31:24]});
      bus(1'b1, 4'h6, 32'h1000);
      exec(rows[k][39:32], {8'h0, rows[k][23:16]});
      rdc(4'h6, "pc", {16'h0, rows[k][15:0]});
      rdc(4'h3, "ccr", {24'h0, rows[k][31:24]});
    end
    $display("branch table done");
    bus(1'b1, 4'h3, 32'hC5);
    bus(1'b1, 4'h4, 32'h1234);
    bus(1'b1, 4'h6, 32'h1000);
    exec(8'h01, 16'h0);
    rdc(4'h6, "pc", 32'h1001);
    rdc(4'h3, "ccr", 32'hC5);
    rdc(4'h4, "x", 32'h1234);
    exec(8'hCE, 16'h4321);
    rdc(4'h4, "x", 32'h4321);
    bus(1'b1, 4'h5, 32'h1FF);
    bus(1'b1, 4'h6, 32'h1000);
    exec(8'hBD, 16'h2000);
    rdc(4'h6, "pc", 32'h2000);
    rdc(4'h5, "sp", 32'h1FD);
    chk("push_lo", 32'h03, {24'h0, bji_mem_model_inst.mem[16'h01FF]});
    chk("push_hi", 32'h10, {24'h0, bji_mem_model_inst.mem[16'h01FE]});
    exec(8'h39, 16'h0);
    rdc(4'h6, "pc", 32'h1003);
    rdc(4'h5, "sp", 32'h1FF);
    bus(1'b1, 4'h6, 32'h1000);
    exec(8'h8D, 16'h7F);
    rdc(4'h6, "pc", 32'h1081);
    chk("bsr_ret", 32'h02, {24'h0, bji_mem_model_inst.mem[16'h01FF]});
    bus(1'b1, 4'h4, 32'h3000);
    exec(8'hAD, 16'hFF);
    rdc(4'h6, "pc", 32'h30FF);
    rdc(4'h7, "ea", 32'h30FF);
    rdc(4'h4, "x", 32'h3000);
    exec(8'h9D, 16'h1234);
    rdc(4'h6, "pc", 32'h34);
    bus(1'b1, 4'h4, 32'h40);
    exec(8'hEE, 16'h02);
    rdc(4'h4, "x", 32'hE7E6);
    bus(1'b1, 4'h3, 32'hC0);
    bus(1'b1, 4'h4, 32'h8000);
    exec(8'h8C, 16'h7FFF);
    rdc(4'h3, "ccr", 32'hC2);
    bus(1'b1, 4'h6, 32'h1000);
    exec(8'h22, 16'h04);
    rdc(4'h6, "pc", 32'h1006);
    bji_mem_model_inst.mem[16'h0101] = 8'hCA;
    bus(1'b1, 4'h5, 32'h100);
    exec(8'h3B, 16'h0);
    rdc(4'h3, "ccr", 32'hCA);
    rdc(4'h4, "x", 32'hA1A0);
    rdc(4'h6, "pc", 32'hA3A2);
    rdc(4'h5, "sp", 32'h107);
    $display("call and index tests done");
    bus(1'b1, 4'h3, 32'hD0);
    bus(1'b1, 4'h1, 32'h3E);
    bus(1'b1, 4'h0, 32'h1);
    repeat (10) @(posedge mclk_in);
    irq_in <= 1'b1;
    repeat (10) @(posedge mclk_in);
    chk("waiting", 32'h1, {31'h0, waiting_out});
    nmi_in <= 1'b1;
    s = 0;
    while (waiting_out !== 1'b0 && s < 20)
    begin
      @(posedge mclk_in);
      s = s + 1;
    end
    chk("woken", 32'h0, {31'h0, waiting_out});
    irq_in <= 1'b0;
    nmi_in <= 1'b0;
    poll;
    bus(1'b1, 4'h3, 32'hC0);
    bus(1'b1, 4'h0, 32'h1);
    irq_in <= 1'b1;
    poll;
    irq_in <= 1'b0;
    rdc(4'h3, "ccr", 32'hD0);
    $display("wait test done");
    tally_and_finish;
  end
endmodule // testbench
